// ===== src/acc_defs.svh
// register offsets, field positions, reset values and timing counts of the calibration control block
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH
// printed offsets are register indices; byte address is four times the index
`define ACC_IDX_ENABLE 8'h61
`define ACC_IDX_CFG_MAIN 8'h62
`define ACC_IDX_CFG_OREF 8'h65
`define ACC_IDX_AVG 8'h68
`define ACC_IDX_STATE 8'h6a
`define ACC_IDX_PIN_CFG 8'h6b
`define ACC_IDX_IRQ_STAT 8'h70
`define ACC_IDX_IRQ_MASK 8'h71
`define ACC_IDX_CTRL 8'h72
`define ACC_RST_ENABLE 8'h01
`define ACC_RST_CFG_MAIN 8'h01
`define ACC_RST_CFG_OREF 8'h01
`define ACC_RST_AVG 8'h61
`define ACC_RST_PIN_CFG 8'h00
`define ACC_RST_IRQ_MASK 8'h00
`define ACC_BIT_ENGINE 0
`define ACC_BIT_FG 0
`define ACC_BIT_BG 1
`define ACC_BIT_FG_OS 2
`define ACC_BIT_BG_OS 3
`define ACC_BIT_OREF 2
`define ACC_BIT_START 0
`define ACC_BIT_STOP_BG 1
`define ACC_BIT_DONE 0
`define ACC_BIT_STOPPED 1
`define ACC_FLD_OFFSET_AVERAGING_DEPTH_HI 6
`define ACC_FLD_OFFSET_AVERAGING_DEPTH_LO 4
`define ACC_FLD_LIN_AVG_HI 2
`define ACC_FLD_LIN_AVG_LO 0
`define ACC_FLD_CODE_HI 4
`define ACC_FLD_CODE_LO 2
`define ACC_FLD_PINSEL_HI 2
`define ACC_FLD_PINSEL_LO 1
// base length of one averaging step, scaled by 2**depth
`define ACC_STEP_NS 80
`define ACC_CLK_NS 5
`define ACC_STEP_CYCLES ((`ACC_STEP_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)
`endif

// ===== src/acc_pkg.sv
// types shared by the calibration control block
package acc_pkg;
    typedef enum logic [2:0] {
        ACC_IDLE,
        ACC_CLEAR,
        ACC_FG_LIN,
        ACC_FG_OFS,
        ACC_BG_RUN,
        ACC_BG_STOP
    } acc_state_e;
    typedef logic [7:0] acc_byte_t;
endpackage : acc_pkg

// ===== src/acc_timer.sv
// averaging-phase timer: counts base steps times two to the power of the depth
`timescale 1ns/1ps
`include "acc_defs.svh"
module acc_timer import acc_pkg::*; #(
    parameter int STEP = `ACC_STEP_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [2:0] depth,
    output logic done
);
    logic [17:0] cnt_q;
    logic run_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 18'h0;
            run_q <= 1'b0;
        end else if (start) begin
            cnt_q <= 18'((STEP << depth) - 1);
            run_q <= 1'b1;
        end else if (run_q) begin
            if (cnt_q == 18'h0) begin
                run_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q - 18'h1;
            end
        end
    end

    // no term in start here: the sequencer restarts from done, which would close a loop
    assign done = run_q && (cnt_q == 18'h0);
endmodule : acc_timer

// ===== src/acc_core.sv
// calibration control: APB registers, calibration sequencer, status pin and interrupt
`timescale 1ns/1ps
`include "acc_defs.svh"
module acc_core import acc_pkg::*; #(
    parameter int STEP = `ACC_STEP_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic alarm_in,
    output logic calibration_state_pin,
    output logic offset_reference_select,
    output logic offset_calibration_active,
    output logic irq
);
    acc_byte_t enable_q;
    acc_byte_t cfg_main_q;
    acc_byte_t cfg_oref_q;
    acc_byte_t avg_q;
    acc_byte_t pin_cfg_q;
    acc_byte_t irq_stat_q;
    acc_byte_t irq_mask_q;
    acc_state_e state_q;
    logic foreground_complete_flag_q;
    logic stopped_q;
    logic stop_req_q;
    logic alarm_s1_q;
    logic alarm_s2_q;
    logic pin_q;
    logic ofs_q;
    logic timer_start;
    logic timer_done;
    logic [2:0] timer_depth;
    logic start_pulse;
    logic done_rise;
    logic stop_rise;
    logic [7:0] reg_idx;
    logic idx_ok;
    logic wr_en;
    logic rd_en;
    logic wr_lane0;
    acc_byte_t rd_byte;

    logic foreground_run_select;
    logic background_run_enable;
    logic foreground_offset_enable;
    logic background_offset_enable;
    logic [2:0] offset_averaging_depth;
    logic [2:0] linearity_averaging_depth;
    logic [2:0] state_code;
    logic [1:0] pin_select;

    assign foreground_run_select = cfg_main_q[`ACC_BIT_FG];
    assign background_run_enable = cfg_main_q[`ACC_BIT_BG];
    assign foreground_offset_enable = cfg_main_q[`ACC_BIT_FG_OS] & foreground_run_select;
    assign background_offset_enable = cfg_main_q[`ACC_BIT_BG_OS] & background_run_enable;
    assign offset_averaging_depth = avg_q[`ACC_FLD_OFFSET_AVERAGING_DEPTH_HI:`ACC_FLD_OFFSET_AVERAGING_DEPTH_LO];
    assign linearity_averaging_depth = avg_q[`ACC_FLD_LIN_AVG_HI:`ACC_FLD_LIN_AVG_LO];
    assign pin_select = pin_cfg_q[`ACC_FLD_PINSEL_HI:`ACC_FLD_PINSEL_LO];

    // apb decode: zero-wait, byte address is index times four
    assign reg_idx = paddr[9:2];
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign wr_lane0 = wr_en && pstrb[0];

    always_comb begin
        idx_ok = 1'b1;
        rd_byte = 8'h00;
        unique case (reg_idx)
            `ACC_IDX_ENABLE: rd_byte = enable_q;
            `ACC_IDX_CFG_MAIN: rd_byte = cfg_main_q;
            `ACC_IDX_CFG_OREF: rd_byte = cfg_oref_q;
            `ACC_IDX_AVG: rd_byte = avg_q;
            `ACC_IDX_STATE: rd_byte = {3'h0, state_code, stopped_q, foreground_complete_flag_q};
            `ACC_IDX_PIN_CFG: rd_byte = pin_cfg_q;
            `ACC_IDX_IRQ_STAT: rd_byte = irq_stat_q;
            `ACC_IDX_IRQ_MASK: rd_byte = irq_mask_q;
            `ACC_IDX_CTRL: rd_byte = {6'h00, stop_req_q, 1'b0};
            default: idx_ok = 1'b0;
        endcase
        if (paddr[11:10] != 2'h0 || paddr[1:0] != 2'h0) begin
            idx_ok = 1'b0;
        end
    end

    assign pslverr = psel && penable && !idx_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {24'h0, rd_byte};
        end
    end

    // configuration registers; state register ignores writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_q <= `ACC_RST_ENABLE;
            cfg_main_q <= `ACC_RST_CFG_MAIN;
            cfg_oref_q <= `ACC_RST_CFG_OREF;
            avg_q <= `ACC_RST_AVG;
            pin_cfg_q <= `ACC_RST_PIN_CFG;
            irq_mask_q <= `ACC_RST_IRQ_MASK;
        end else if (wr_lane0 && idx_ok) begin
            unique case (reg_idx)
                `ACC_IDX_ENABLE: enable_q <= pwdata[7:0];
                `ACC_IDX_CFG_MAIN: cfg_main_q <= pwdata[7:0];
                `ACC_IDX_CFG_OREF: cfg_oref_q <= pwdata[7:0];
                `ACC_IDX_AVG: avg_q <= pwdata[7:0];
                `ACC_IDX_PIN_CFG: pin_cfg_q <= pwdata[7:0];
                `ACC_IDX_IRQ_MASK: irq_mask_q <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // start pulse: writing 1 to control bit 0 launches a new run
    assign start_pulse = wr_lane0 && (reg_idx == `ACC_IDX_CTRL) && pwdata[`ACC_BIT_START]
        && enable_q[`ACC_BIT_ENGINE];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_req_q <= 1'b0;
        end else if (wr_lane0 && reg_idx == `ACC_IDX_CTRL) begin
            stop_req_q <= pwdata[`ACC_BIT_STOP_BG];
        end
    end

    // sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ACC_IDLE;
        end else if (!enable_q[`ACC_BIT_ENGINE]) begin
            state_q <= ACC_IDLE;
        end else if (start_pulse) begin
            state_q <= ACC_CLEAR;
        end else begin
            unique case (state_q)
                ACC_IDLE: state_q <= ACC_IDLE;
                ACC_CLEAR: begin
                    if (foreground_run_select) begin
                        state_q <= ACC_FG_LIN;
                    end else if (background_run_enable) begin
                        state_q <= ACC_BG_RUN;
                    end else begin
                        state_q <= ACC_IDLE;
                    end
                end
                ACC_FG_LIN: begin
                    if (timer_done) begin
                        state_q <= foreground_offset_enable ? ACC_FG_OFS :
                            (background_run_enable ? ACC_BG_RUN : ACC_IDLE);
                    end
                end
                ACC_FG_OFS: begin
                    if (timer_done) begin
                        state_q <= background_run_enable ? ACC_BG_RUN : ACC_IDLE;
                    end
                end
                ACC_BG_RUN: begin
                    if (!background_run_enable) begin
                        state_q <= ACC_IDLE;
                    end else if (stop_req_q && timer_done) begin
                        state_q <= ACC_BG_STOP;
                    end
                end
                ACC_BG_STOP: begin
                    if (!background_run_enable) begin
                        state_q <= ACC_IDLE;
                    end else if (!stop_req_q) begin
                        state_q <= ACC_BG_RUN;
                    end
                end
            endcase
        end
    end

    // phase timer restarts on entry to every timed phase except background run entered from the foreground offset phase, and on each background step
    assign timer_start = (state_q == ACC_CLEAR)
        || (state_q == ACC_FG_LIN && timer_done)
        || (state_q == ACC_BG_RUN && timer_done)
        || (state_q == ACC_BG_STOP && !stop_req_q);
    always_comb begin
        timer_depth = linearity_averaging_depth;
        if (state_q == ACC_CLEAR && !foreground_run_select) begin
            timer_depth = background_offset_enable ? offset_averaging_depth : linearity_averaging_depth;
        end else if (state_q == ACC_FG_LIN && foreground_offset_enable) begin
            timer_depth = offset_averaging_depth;
        end else if (state_q != ACC_CLEAR && state_q != ACC_FG_LIN && background_offset_enable) begin
            timer_depth = offset_averaging_depth;
        end
    end

    acc_timer #(
        .STEP(STEP)
    ) i_acc_timer (
        .pclk(pclk),
        .presetn(presetn),
        .start(timer_start),
        .depth(timer_depth),
        .done(timer_done)
    );

    // foreground done flag: cleared at run start, set on finish or skip
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            foreground_complete_flag_q <= 1'b0;
        end else if (state_q == ACC_CLEAR) begin
            foreground_complete_flag_q <= !foreground_run_select;
        end else if ((state_q == ACC_FG_LIN && timer_done && !foreground_offset_enable)
            || (state_q == ACC_FG_OFS && timer_done)) begin
            foreground_complete_flag_q <= 1'b1;
        end else if (start_pulse) begin
            foreground_complete_flag_q <= 1'b0;
        end
    end

    // stopped flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stopped_q <= 1'b0;
        end else if (start_pulse || state_q == ACC_BG_RUN) begin
            stopped_q <= 1'b0;
        end else if (state_q == ACC_BG_STOP) begin
            stopped_q <= 1'b1;
        end else if (!background_run_enable && foreground_complete_flag_q) begin
            stopped_q <= 1'b1;
        end
    end

    always_comb begin
        state_code = 3'h0;
        unique case (state_q)
            ACC_IDLE: state_code = 3'h0;
            ACC_CLEAR: state_code = 3'h1;
            ACC_FG_LIN: state_code = 3'h2;
            ACC_FG_OFS: state_code = 3'h3;
            ACC_BG_RUN: state_code = 3'h4;
            ACC_BG_STOP: state_code = 3'h5;
        endcase
    end

    // offset reference: 0 mid-code, 1 spare converter samples
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            offset_reference_select <= 1'b0;
            ofs_q <= 1'b0;
        end else begin
            offset_reference_select <= cfg_oref_q[`ACC_BIT_OREF];
            ofs_q <= (state_q == ACC_FG_OFS) || (state_q == ACC_BG_RUN && background_offset_enable);
        end
    end
    assign offset_calibration_active = ofs_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_s1_q <= 1'b0;
            alarm_s2_q <= 1'b0;
        end else begin
            alarm_s1_q <= alarm_in;
            alarm_s2_q <= alarm_s1_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q <= 1'b0;
        end else begin
            unique case (pin_select)
                2'h0: pin_q <= foreground_complete_flag_q;
                2'h1: pin_q <= stopped_q;
                2'h2: pin_q <= alarm_s2_q;
                2'h3: pin_q <= 1'b0;
            endcase
        end
    end
    assign calibration_state_pin = pin_q;

    // sticky events; set wins over the read that clears
    logic done_d1_q;
    logic stop_d1_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_d1_q <= 1'b0;
            stop_d1_q <= 1'b0;
        end else begin
            done_d1_q <= foreground_complete_flag_q;
            stop_d1_q <= stopped_q;
        end
    end
    assign done_rise = foreground_complete_flag_q && !done_d1_q;
    assign stop_rise = stopped_q && !stop_d1_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= 8'h00;
        end else begin
            if (rd_en && reg_idx == `ACC_IDX_IRQ_STAT) begin
                irq_stat_q <= 8'h00;
            end
            if (done_rise) begin
                irq_stat_q[`ACC_BIT_DONE] <= 1'b1;
            end
            if (stop_rise) begin
                irq_stat_q[`ACC_BIT_STOPPED] <= 1'b1;
            end
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);
endmodule : acc_core

// ===== testbench/acc_core_chk.sv
// concurrent checks on the ports of the calibration control block
`timescale 1ns/1ps
module acc_core_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic alarm_in,
    input wire logic calibration_state_pin,
    input wire logic offset_reference_select,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wen;
    logic rdc;
    logic [7:0] en_q, main_q, oref_q, avg_q, pin_q, mask_q;
    assign wen = psel && penable && pwrite && pready && pstrb[0];
    assign rdc = psel && penable && !pwrite;
    // shadow copies rebuilt from bus traffic alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= 8'h01;
            main_q <= 8'h01;
            oref_q <= 8'h01;
            avg_q <= 8'h61;
            pin_q <= 8'h00;
            mask_q <= 8'h00;
        end else if (wen) begin
            case (paddr)
                12'h184: en_q <= pwdata[7:0];
                12'h188: main_q <= pwdata[7:0];
                12'h194: oref_q <= pwdata[7:0];
                12'h1a0: avg_q <= pwdata[7:0];
                12'h1ac: pin_q <= pwdata[7:0];
                12'h1c4: mask_q <= pwdata[7:0];
                default: ;
            endcase
        end
    end
    property p_en_rd; rdc && paddr == 12'h184 |-> prdata == {24'h0, en_q}; endproperty
    a_en_rd: assert property (p_en_rd) else $error("enable readback wrong");
    property p_main_rd; rdc && paddr == 12'h188 |-> prdata == {24'h0, main_q}; endproperty
    a_main_rd: assert property (p_main_rd) else $error("config readback wrong");
    property p_avg_rd; rdc && paddr == 12'h1a0 |-> prdata == {24'h0, avg_q}; endproperty
    a_avg_rd: assert property (p_avg_rd) else $error("averaging readback wrong");
    property p_oref; oref_q == $past(oref_q) && oref_q == $past(oref_q, 2) |-> offset_reference_select == oref_q[2];
    endproperty
    a_oref: assert property (p_oref) else $error("reference select output wrong");
    property p_pin_low; (pin_q[2:1] == 2'd3)[*3] |-> !calibration_state_pin; endproperty
    a_pin_low: assert property (p_pin_low) else $error("state pin not low");
    property p_pin_alarm; (pin_q[2:1] == 2'd2 && $stable(alarm_in))[*5] |-> calibration_state_pin == alarm_in;
    endproperty
    a_pin_alarm: assert property (p_pin_alarm) else $error("state pin not following alarm");
    property p_irq_masked; (mask_q == 8'h00)[*2] |-> !irq; endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("interrupt with all masked");
    property p_misalign; psel && penable && paddr[1:0] != 2'b00 |-> pslverr; endproperty
    a_misalign: assert property (p_misalign) else $error("misaligned access not refused");
    property p_state_rd; rdc && paddr == 12'h1a8 |-> !pslverr && prdata[31:5] == 27'h0; endproperty
    a_state_rd: assert property (p_state_rd) else $error("state read malformed");
endmodule : acc_core_chk

bind acc_core acc_core_chk i_acc_core_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .alarm_in(alarm_in), .calibration_state_pin(calibration_state_pin),
    .offset_reference_select(offset_reference_select), .irq(irq));

// ===== testbench/tb_adc_calibration_control.sv
// register-level tests of the calibration control block over apb
`timescale 1ns/1ps
module tb_adc_calibration_control;
    logic pclk, presetn, psel, penable, pwrite, alarm_in, pready, pslverr, err_v;
    int os_cycles = 0;
    int os_base;
    logic calibration_state_pin, offset_reference_select, offset_calibration_active, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_v;
    logic [3:0] pstrb;
    int error_cnt, checks;
    logic [11:0] ra [7] = '{12'h184, 12'h188, 12'h194, 12'h1a0, 12'h1ac, 12'h1c4, 12'h1a8};
    logic [7:0] rv [7] = '{8'h01, 8'h01, 8'h01, 8'h61, 8'h00, 8'h00, 8'h00};
    logic pe [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    acc_core #(.STEP(1)) i_acc_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .alarm_in(alarm_in), .calibration_state_pin(calibration_state_pin),
        .offset_reference_select(offset_reference_select),
        .offset_calibration_active(offset_calibration_active), .irq(irq));
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (offset_calibration_active === 1'b1) os_cycles <= os_cycles + 1;
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task conclude;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // waits for pready; the watchdog bounds this loop
        do @(posedge pclk); while (pready !== 1'b1);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task poll(input logic [31:0] m, input logic [31:0] e);
        for (int n = 0; n < 300; n++) begin
            apb(1'b0, 12'h1a8, 32'h0);
            if ((rd_v & m) === e) break;
        end
        chk(rd_v & m, e);
    endtask : poll
    initial begin
        #200000;
        error_cnt++;
        conclude();
    end
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, alarm_in} = 4'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, ra[i], 32'h0);
            chk(rd_v, {24'h0, rv[i]});
        end
        apb(1'b0, 12'h1fc, 32'h0);
        chk({31'h0, err_v}, 32'h1);
        chk(rd_v, 32'h0);
        apb(1'b0, 12'h186, 32'h0);
        chk({31'h0, err_v}, 32'h1);
        apb(1'b1, 12'h1a8, 32'hff);
        apb(1'b0, 12'h1a8, 32'h0);
        chk(rd_v, 32'h0);
        $display("test reset_and_access done");
        apb(1'b1, 12'h1c4, 32'h1);
        apb(1'b1, 12'h188, 32'h0);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, 12'h1c8, 32'h1);
        poll(32'h3, 32'h3);
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, 12'h1c0, 32'h0);
        chk(rd_v, 32'h3);
        apb(1'b0, 12'h1c0, 32'h0);
        chk(rd_v, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("test skip_and_interrupt done");
        // done and stopped both high here, so codes 0 and 1 read high
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 12'h1ac, i << 1);
            repeat (4) @(posedge pclk);
            chk({31'h0, calibration_state_pin}, {31'h0, pe[i]});
        end
        alarm_in <= 1'b1;
        apb(1'b1, 12'h1ac, 32'h4);
        repeat (4) @(posedge pclk);
        chk({31'h0, calibration_state_pin}, 32'h1);
        $display("test state_pin done");
        apb(1'b1, 12'h1a0, 32'h13);
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, 12'h188, i ? 32'h5 : 32'h1);
            os_base = os_cycles;
            apb(1'b1, 12'h1c8, 32'h1);
            apb(1'b0, 12'h1a8, 32'h0);
            chk(rd_v & 32'h1, 32'h0);
            poll(32'h3, 32'h3);
            chk({31'h0, os_cycles != os_base}, i);
        end
        $display("test foreground_run done");
        apb(1'b1, 12'h188, 32'h0b);
        apb(1'b1, 12'h1c8, 32'h1);
        poll(32'h1f, 32'h11);
        apb(1'b1, 12'h194, 32'h5);
        apb(1'b0, 12'h194, 32'h0);
        chk(rd_v, 32'h5);
        chk({31'h0, offset_reference_select}, 32'h1);
        apb(1'b1, 12'h1c8, 32'h2);
        poll(32'h1e, 32'h16);
        apb(1'b1, 12'h1c8, 32'h0);
        poll(32'h2, 32'h0);
        apb(1'b1, 12'h194, 32'h1);
        apb(1'b0, 12'h194, 32'h0);
        chk({31'h0, offset_reference_select}, 32'h0);
        $display("test background_run done");
        conclude();
    end
endmodule : tb_adc_calibration_control
